// ### pkg/etpc_pkg.sv
package etpc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int unsigned NUM_CHANNELS = 8;
    localparam int unsigned NUM_SLOTS = 32;
    localparam int unsigned APB_ADDR_W = 12;
    // Register indices; byte address is four times the index
    localparam logic [9:0] CHANNEL_STRIDE = 10'h080;
    localparam logic [6:0] TX_PAYLOAD_CONFIG = 7'h60;
    localparam logic [6:0] TX_PAYLOAD_ACCESS_STATUS = 7'h61;
    localparam logic [6:0] TX_PAYLOAD_INDIRECT_ADDR_CTRL = 7'h62;
    localparam logic [6:0] TX_PAYLOAD_INDIRECT_DATA = 7'h63;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int unsigned CFG_ENABLE_BIT = 0;
    localparam int unsigned STATUS_BUSY_BIT = 7;
    localparam int unsigned ACCESS_DIRECTION_BIT = 7;
    localparam logic [6:0] INDIRECT_FIRST = 7'h20;
    localparam logic [1:0] REGION_CONTROL = 2'h1;
    localparam logic [1:0] REGION_CODE = 2'h2;
    localparam logic [1:0] REGION_SIGNALING = 2'h3;
    localparam logic [7:0] CONTROL_MASK = 8'hBC;
    localparam logic [7:0] SIGNALING_MASK = 8'h1F;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLOCK_PERIOD_NS = 10;
    localparam int unsigned ACCESS_TIME_NS = 490;
    localparam int unsigned BUSY_CYCLES = ACCESS_TIME_NS / CLOCK_PERIOD_NS;
    localparam logic [5:0] BUSY_LAST = 6'(BUSY_CYCLES - 1);

    // ****************************************************************
    // Digital milliwatt sequences, first byte in the top bits
    // ****************************************************************
    localparam logic [63:0] MILLIWATT_ALAW = 64'h34212134B4A1A1B4;
    localparam logic [63:0] MILLIWATT_MULAW = 64'h1E0B0B1E9E8B8B9E;

    // ****************************************************************
    // Indirect byte layouts
    // ****************************************************************
    typedef struct packed {
        logic substitute_select;
        logic reserved_6;
        logic operation_select_high;
        logic operation_select_low;
        logic test;
        logic loop;
        logic [1:0] reserved_1_0;
    } etpc_slot_ctrl_t;

    typedef struct packed {
        logic [2:0] reserved_7_5;
        logic signaling_origin_select;
        logic [3:0] abcd;
    } etpc_slot_sig_t;

    typedef struct packed {
        logic access_direction;
        logic [6:0] index;
    } etpc_addr_ctrl_t;

endpackage

// ### core/etpc_tx_payload_conditioner.sv
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
// Function
// - Eight channel copies, register groups spaced 0x80 apart.
// - Enable bit gates every per-slot function; zero disables them all.
// - Busy flag high during an indirect access, low otherwise.
// - Busy clears on a clock edge after the 490 ns access.
// - Writing address/control with a valid index while idle launches one indirect access.
// - Direction bit 7: zero writes buffer to target, one reads target.
// - Index field covers indirect registers 20H to 7FH.
// - Indirect read places the byte in the buffer within 490 ns.
// - Control bytes 20H-3FH, code bytes 40H-5FH, signaling 61H-7FH.
// - Without substitution: none, odd, even or all bits inverted.
// - Substitution: code byte, A-law or mu-law milliwatt pattern.
// - Test bit sends slot to checker or fills it from generator.
// - Checker and generator slots form one concatenated stream each.
// - Loopback sends aligned receive payload in the slot.
// - Loopback in receive slave mode needs transmit slave and shared timing.
// - Priority: check, loopback, milliwatt, generator, code, inversion.
// - Code byte replaces slot data, bit 7 sent first as MSB.
// - Signaling source bit acts only when CAS is selected.
// - Source bit zero uses signaling pin, one uses stored ABCD.
module etpc_tx_payload_conditioner (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [etpc_pkg::APB_ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic tx_common_clock_in,
    input wire logic tx_common_frame_pulse_in,
    input wire logic [etpc_pkg::NUM_CHANNELS-1:0] tx_serial_data_in,
    input wire logic [etpc_pkg::NUM_CHANNELS-1:0] tx_signaling_in,
    input wire logic [etpc_pkg::NUM_CHANNELS-1:0] rx_payload_in,
    input wire logic [etpc_pkg::NUM_CHANNELS-1:0] rx_clock_master_in,
    input wire logic [etpc_pkg::NUM_CHANNELS-1:0] tx_clock_slave_in,
    input wire logic [etpc_pkg::NUM_CHANNELS-1:0] cas_select_in,
    input wire logic [etpc_pkg::NUM_CHANNELS-1:0] pattern_direction_select_in,
    input wire logic [etpc_pkg::NUM_CHANNELS-1:0] gen_bit_in,
    output logic [etpc_pkg::NUM_CHANNELS-1:0] tx_data_out,
    output logic [etpc_pkg::NUM_CHANNELS-1:0] tx_signaling_out,
    output logic [etpc_pkg::NUM_CHANNELS-1:0] check_bit_out,
    output logic [etpc_pkg::NUM_CHANNELS-1:0] check_valid_out,
    output logic [etpc_pkg::NUM_CHANNELS-1:0] gen_advance_out
);
    import etpc_pkg::*;

    // ****************************************************************
    // Link input synchronisers
    // ****************************************************************
    logic [1:0] clk_meta;
    logic clk_sync;
    logic [1:0] fp_sync;
    logic [NUM_CHANNELS-1:0] data_meta;
    logic [NUM_CHANNELS-1:0] data_sync;
    logic [NUM_CHANNELS-1:0] sig_meta;
    logic [NUM_CHANNELS-1:0] sig_sync;
    logic link_rise;

    // clk_sync is the previous synchronised level, used for the edge
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            clk_meta <= 2'h0;
            clk_sync <= 1'b0;
            fp_sync <= 2'h0;
            data_meta <= '0;
            data_sync <= '0;
            sig_meta <= '0;
            sig_sync <= '0;
        end else begin
            clk_meta <= {clk_meta[0], tx_common_clock_in};
            clk_sync <= clk_meta[1];
            fp_sync <= {fp_sync[0], tx_common_frame_pulse_in};
            data_meta <= tx_serial_data_in;
            data_sync <= data_meta;
            sig_meta <= tx_signaling_in;
            sig_sync <= sig_meta;
        end
    end

    // Clock, frame pulse, data and signaling pins pass the same two stages, so data stays aligned to the edge
    always_comb begin
        link_rise = clk_meta[1] & ~clk_sync;
    end

    // ****************************************************************
    // Frame position and milliwatt phase
    // ****************************************************************
    logic [7:0] bit_pos;
    logic [7:0] next_bit_pos;
    logic [2:0] mw_phase;
    logic [4:0] cur_slot;
    logic [2:0] cur_bit;

    // Frame pulse marks the first bit of slot 0
    always_comb begin
        next_bit_pos = fp_sync[1] ? 8'h00 : 8'(bit_pos + 8'h01);
        cur_slot = next_bit_pos[7:3];
        cur_bit = next_bit_pos[2:0];
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            bit_pos <= 8'hFF;
            mw_phase <= 3'h0;
        end else if (link_rise) begin
            bit_pos <= next_bit_pos;
            if (next_bit_pos == 8'hFF) begin
                mw_phase <= 3'(mw_phase + 3'h1);
            end
        end
    end

    // ****************************************************************
    // APB slave
    // ****************************************************************
    logic [9:0] word_idx;
    logic [2:0] bus_channel;
    logic [6:0] bus_reg;
    logic bus_hit;
    logic apb_start;
    logic apb_write;
    logic [7:0] cfg_q [NUM_CHANNELS];
    logic [7:0] ac_q [NUM_CHANNELS];
    logic [7:0] buf_q [NUM_CHANNELS];
    logic [NUM_CHANNELS-1:0] busy_q;
    logic [7:0] read_byte;

    // Channel groups repeat every CHANNEL_STRIDE indices
    always_comb begin
        word_idx = paddr_in[11:2];
        bus_channel = word_idx[9:7];
        bus_reg = word_idx[6:0];
        bus_hit = (paddr_in[1:0] == 2'h0) && (bus_reg >= TX_PAYLOAD_CONFIG) &&
            (bus_reg <= TX_PAYLOAD_INDIRECT_DATA);
        apb_start = psel_in & penable_in & ~pready_out;
        apb_write = psel_in & penable_in & pready_out & pwrite_in;
        read_byte = 8'h00;
        unique case (bus_reg)
            TX_PAYLOAD_CONFIG: read_byte = cfg_q[bus_channel];
            TX_PAYLOAD_ACCESS_STATUS: read_byte = {busy_q[bus_channel], 7'h00};
            TX_PAYLOAD_INDIRECT_ADDR_CTRL: read_byte = ac_q[bus_channel];
            TX_PAYLOAD_INDIRECT_DATA: read_byte = buf_q[bus_channel];
            default: read_byte = 8'h00;
        endcase
    end

    // One wait state: pready rises in the second access-phase cycle
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h00000000;
        end else begin
            pready_out <= apb_start;
            pslverr_out <= apb_start & ~bus_hit;
            if (apb_start) begin
                prdata_out <= (bus_hit && !pwrite_in) ? {24'h000000, read_byte} : 32'h00000000;
            end
        end
    end

    // ****************************************************************
    // Per-channel indirect store and payload path
    // ****************************************************************
    for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_channel
        logic [7:0] ctrl_mem [NUM_SLOTS];
        logic [7:0] code_mem [NUM_SLOTS];
        logic [7:0] sig_mem [NUM_SLOTS];
        logic [5:0] busy_cnt;
        logic reg_wr;
        logic launch;
        logic finish;
        etpc_addr_ctrl_t ac;
        logic [7:0] target_byte;
        etpc_slot_ctrl_t slot_ctrl;
        etpc_slot_sig_t slot_sig;
        logic [7:0] slot_code;
        logic enabled;
        logic loop_ok;
        logic next_data;
        logic next_sig;
        logic next_check;
        logic next_gen;
        logic invert;

        always_comb begin
            reg_wr = apb_write && bus_hit && (bus_channel == 3'(ch));
            ac = etpc_addr_ctrl_t'(ac_q[ch]);
            // An address/control write during busy is dropped, register and buffer untouched
            launch = reg_wr && (bus_reg == TX_PAYLOAD_INDIRECT_ADDR_CTRL) && !busy_q[ch] &&
                (pwdata_in[6:0] >= INDIRECT_FIRST);
            finish = busy_q[ch] && (busy_cnt == 6'h00);
            target_byte = 8'h00;
            unique case (ac.index[6:5])
                REGION_CONTROL: target_byte = ctrl_mem[ac.index[4:0]];
                REGION_CODE: target_byte = code_mem[ac.index[4:0]];
                REGION_SIGNALING: target_byte = (ac.index[4:0] == 5'h00) ? 8'h00 : sig_mem[ac.index[4:0]];
                default: target_byte = 8'h00;
            endcase
        end

        always_ff @(posedge ref_clk_in) begin
            if (!rst_b_in) begin
                cfg_q[ch] <= REG_RESET;
            end else if (reg_wr && (bus_reg == TX_PAYLOAD_CONFIG)) begin
                cfg_q[ch] <= {7'h00, pwdata_in[CFG_ENABLE_BIT]};
            end
        end

        always_ff @(posedge ref_clk_in) begin
            if (!rst_b_in) begin
                ac_q[ch] <= REG_RESET;
                busy_q[ch] <= 1'b0;
                busy_cnt <= 6'h00;
            end else if (launch) begin
                ac_q[ch] <= pwdata_in[7:0];
                busy_q[ch] <= 1'b1;
                busy_cnt <= BUSY_LAST;
            end else if (busy_q[ch]) begin
                if (finish) begin
                    busy_q[ch] <= 1'b0;
                end else begin
                    busy_cnt <= 6'(busy_cnt - 6'h01);
                end
            end else if (reg_wr && (bus_reg == TX_PAYLOAD_INDIRECT_ADDR_CTRL)) begin
                ac_q[ch] <= pwdata_in[7:0];
            end
        end

        // Read result lands as busy falls; it wins over a host buffer write
        always_ff @(posedge ref_clk_in) begin
            if (!rst_b_in) begin
                buf_q[ch] <= REG_RESET;
            end else if (finish && ac.access_direction) begin
                buf_q[ch] <= target_byte;
            end else if (reg_wr && (bus_reg == TX_PAYLOAD_INDIRECT_DATA)) begin
                buf_q[ch] <= pwdata_in[7:0];
            end
        end

        // Per-slot bytes have no reset; the enable bit keeps them out of the path
        always_ff @(posedge ref_clk_in) begin
            if (finish && !ac.access_direction) begin
                unique case (ac.index[6:5])
                    REGION_CONTROL: ctrl_mem[ac.index[4:0]] <= buf_q[ch] & CONTROL_MASK;
                    REGION_CODE: code_mem[ac.index[4:0]] <= buf_q[ch];
                    REGION_SIGNALING: sig_mem[ac.index[4:0]] <= buf_q[ch] & SIGNALING_MASK;
                    default: ;
                endcase
            end
        end

        always_comb begin
            slot_ctrl = etpc_slot_ctrl_t'(ctrl_mem[cur_slot]);
            slot_sig = etpc_slot_sig_t'(sig_mem[cur_slot]);
            slot_code = code_mem[cur_slot];
            enabled = cfg_q[ch][CFG_ENABLE_BIT];
            // Slave-mode loopback relies on shared clock and frame pulse
            loop_ok = rx_clock_master_in[ch] | tx_clock_slave_in[ch];
            // Bit 0 of the slot is sent first and is the MSB
            invert = (slot_ctrl.operation_select_high & cur_bit[0]) |
                (slot_ctrl.operation_select_low & ~cur_bit[0]);
            next_check = 1'b0;
            next_gen = 1'b0;
            next_data = data_sync[ch];
            if (!enabled) begin
                next_data = data_sync[ch];
            end else if (slot_ctrl.test && pattern_direction_select_in[ch]) begin
                next_check = 1'b1;
            end else if (slot_ctrl.loop && loop_ok) begin
                next_data = rx_payload_in[ch];
            end else if (slot_ctrl.substitute_select && slot_ctrl.operation_select_low) begin
                next_data = slot_ctrl.operation_select_high ? MILLIWATT_MULAW[{~mw_phase, ~cur_bit}] :
                    MILLIWATT_ALAW[{~mw_phase, ~cur_bit}];
            end else if (slot_ctrl.test) begin
                next_gen = 1'b1;
                next_data = gen_bit_in[ch];
            end else if (slot_ctrl.substitute_select) begin
                next_data = slot_code[~cur_bit];
            end else begin
                next_data = data_sync[ch] ^ invert;
            end
            next_sig = sig_sync[ch];
            if (enabled && cas_select_in[ch] && (cur_slot != 5'h00) && slot_sig.signaling_origin_select &&
                cur_bit[2]) begin
                next_sig = slot_sig.abcd[~cur_bit[1:0]];
            end
        end

        // Checker and generator see only the selected bits, one after another
        always_ff @(posedge ref_clk_in) begin
            if (!rst_b_in) begin
                tx_data_out[ch] <= 1'b0;
                tx_signaling_out[ch] <= 1'b0;
                check_bit_out[ch] <= 1'b0;
                check_valid_out[ch] <= 1'b0;
                gen_advance_out[ch] <= 1'b0;
            end else begin
                check_valid_out[ch] <= link_rise & next_check;
                gen_advance_out[ch] <= link_rise & next_gen;
                if (link_rise) begin
                    tx_data_out[ch] <= next_data;
                    tx_signaling_out[ch] <= next_sig;
                    check_bit_out[ch] <= data_sync[ch];
                end
            end
        end
    end

endmodule

// ### tb/etpc_tx_payload_conditioner_properties.sv
`timescale 1ns/100ps
module etpc_tx_payload_conditioner_properties (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [etpc_pkg::APB_ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic tx_common_clock_in,
    input wire logic [etpc_pkg::NUM_CHANNELS-1:0] tx_data_out,
    input wire logic [etpc_pkg::NUM_CHANNELS-1:0] gen_advance_out
);
    import etpc_pkg::*;
    logic [5:0] since_launch;
    logic [3:0] since_rise;
    logic link_q;
    logic [7:0] addr_shadow;
    logic cfg_shadow;
    wire logic [6:0] idx = paddr_in[8:2];
    // Channel 0 only; other groups are covered by the error map
    wire logic commit = psel_in && penable_in && pready_out && paddr_in[11:9] == 3'h0 && paddr_in[1:0] == 2'h0;
    wire logic idle = since_launch >= 6'h34;
    wire logic wr_ac = commit && pwrite_in && idx == TX_PAYLOAD_INDIRECT_ADDR_CTRL;
    wire logic launch = wr_ac && idle && pwdata_in[6:0] >= INDIRECT_FIRST;

    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            since_launch <= 6'h3F;
        end else if (launch) begin
            since_launch <= 6'h00;
        end else if (since_launch != 6'h3F) begin
            since_launch <= since_launch + 6'h01;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        link_q <= tx_common_clock_in;
        if (!rst_b_in) begin
            since_rise <= 4'hF;
        end else if (tx_common_clock_in && !link_q) begin
            since_rise <= 4'h0;
        end else if (since_rise != 4'hF) begin
            since_rise <= since_rise + 4'h1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            addr_shadow <= 8'h00;
            cfg_shadow <= 1'b0;
        end else begin
            if (wr_ac && idle) begin
                addr_shadow <= pwdata_in[7:0];
            end
            if (commit && pwrite_in && idx == TX_PAYLOAD_CONFIG) begin
                cfg_shadow <= pwdata_in[0];
            end
        end
    end

    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence s_taken;
        psel_in && penable_in && !pready_out;
    endsequence
    sequence s_reply;
        pready_out ##1 !pready_out;
    endsequence
    sequence s_status_read;
        commit && !pwrite_in && idx == TX_PAYLOAD_ACCESS_STATUS;
    endsequence

    chk_one_wait: assert property (s_taken |=> s_reply)
        else $error("pready not a single pulse after one wait state");
    chk_error_map: assert property (pready_out |-> pslverr_out == !(paddr_in[1:0] == 2'h0 && idx >= 7'h60 && idx <= 7'h63))
        else $error("pslverr does not match the address map");
    chk_busy_held: assert property (s_status_read ##0 (since_launch >= 6'h02 && since_launch <= 6'h2E) |-> prdata_out[7])
        else $error("busy low during an indirect access");
    chk_busy_clears: assert property (s_status_read ##0 idle |-> prdata_out == 32'h00000000)
        else $error("busy still high after the access time");
    chk_addr_kept: assert property (commit && !pwrite_in && idx == TX_PAYLOAD_INDIRECT_ADDR_CTRL |-> prdata_out[7:0] == addr_shadow)
        else $error("address control changed by a write during busy");
    chk_config_kept: assert property (commit && !pwrite_in && idx == TX_PAYLOAD_CONFIG |-> prdata_out[0] == cfg_shadow)
        else $error("enable bit read back wrong");
    chk_data_timing: assert property ($changed(tx_data_out) |-> since_rise >= 4'h1 && since_rise <= 4'h7)
        else $error("transmit data changed away from a link edge");
    chk_gen_pulse: assert property (gen_advance_out[0] |-> since_rise <= 4'h7 ##1 !gen_advance_out[0] [*5])
        else $error("generator advance not one pulse per link bit");
endmodule

bind etpc_tx_payload_conditioner etpc_tx_payload_conditioner_properties u_props (.ref_clk_in, .rst_b_in,
    .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .tx_common_clock_in, .tx_data_out, .gen_advance_out);

// ### tb/etpc_link_source.sv
`timescale 1ns/100ps
module etpc_link_source #(
    parameter logic [7:0] DATA_BYTE = 8'h5A,
    parameter logic [7:0] LOOP_BYTE = 8'hC3
) (
    input wire logic run_in,
    output logic link_clock_out,
    output logic frame_pulse_out,
    output logic [7:0] data_out,
    output logic [7:0] signaling_out,
    output logic [7:0] loop_data_out,
    output logic [7:0] gen_out,
    output logic [7:0] position_out
);
    // Bits move on the falling link edge so they are settled at the rising one
    task automatic drive();
        frame_pulse_out = position_out == 8'h00;
        data_out = {8{DATA_BYTE[~position_out[2:0]]}};
        signaling_out = {8{position_out[0]}};
        loop_data_out = {8{LOOP_BYTE[~position_out[2:0]]}};
        gen_out = 8'hFF;
    endtask

    // Clock stands still between frames; 41/39 keeps its rising edge off the system clock edges
    initial begin
        link_clock_out = 1'b0;
        position_out = 8'h00;
        drive();
        forever begin
            wait (run_in === 1'b1);
            #41 link_clock_out = 1'b1;
            #39 link_clock_out = 1'b0;
            position_out = position_out + 8'h01;
            drive();
        end
    end
endmodule

// ### tb/etpc_tx_payload_conditioner_bench.sv
`timescale 1ns/100ps
module etpc_tx_payload_conditioner_bench;
    import etpc_pkg::*;
    logic clk;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic run = 1'b0;
    logic mode = 1'b0;
    logic [APB_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwd = '0;
    logic [31:0] prd;
    logic prdy, perr, lk, fp;
    logic [7:0] sd, sg, rxp, gen, txd, pos, rd;
    logic err;
    logic [7:0] tsg, cb, cv, chk_sr;
    logic [7:0] capt [NUM_SLOTS];
    logic [7:0] capg [NUM_SLOTS];
    logic [7:0] ctl [8] = '{8'h30, 8'h80, 8'h20, 8'h10, 8'h00, 8'h84, 8'h88, 8'h90};
    logic [7:0] exp [8] = '{8'hA5, 8'h3C, 8'h0F, 8'hF0, 8'h5A, 8'hC3, 8'hFF, MILLIWATT_ALAW[55:48]};
    logic [7:0] rb_idx [3] = '{8'h20, 8'h61, 8'h43};
    logic [7:0] rb_val [3] = '{8'hBC, 8'h1F, 8'h3C};
    int n_fail = 0;
    int n_tests = 0;
    int n_cv = 0;

    etpc_tx_payload_conditioner dut (.ref_clk_in(clk), .rst_b_in(rst_b), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
        .pslverr_out(perr), .tx_common_clock_in(lk), .tx_common_frame_pulse_in(fp), .tx_serial_data_in(sd),
        .tx_signaling_in(sg), .rx_payload_in(rxp), .rx_clock_master_in({8{!mode}}), .tx_clock_slave_in({8{mode}}),
        .cas_select_in({8{mode}}), .pattern_direction_select_in({8{mode}}), .gen_bit_in(gen), .tx_data_out(txd),
        .tx_signaling_out(tsg), .check_bit_out(cb), .check_valid_out(cv), .gen_advance_out());
    etpc_link_source src (.run_in(run), .link_clock_out(lk), .frame_pulse_out(fp), .data_out(sd),
        .signaling_out(sg), .loop_data_out(rxp), .gen_out(gen), .position_out(pos));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Output shown at a link rise belongs to the previous bit position
    always @(posedge lk) begin
        capt[5'((pos - 8'h01) >> 3)] = {capt[5'((pos - 8'h01) >> 3)][6:0], txd[0]};
        capg[5'((pos - 8'h01) >> 3)] = {capg[5'((pos - 8'h01) >> 3)][6:0], tsg[0]};
    end

    // Checker stream: one bit per valid pulse, oldest in the top bit
    always @(posedge clk) begin
        if (cv[0] === 1'b1) begin
            chk_sr <= {chk_sr[6:0], cb[0]};
            n_cv <= n_cv + 1;
        end
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input string name, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic apb(input logic wr, input logic [6:0] idx, input logic [7:0] wd, input int ch = 0);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= 12'((int'(idx) + ch * 128) * 4);
        pwd <= {24'h000000, wd};
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (prdy !== 1'b1);
        rd = prd[7:0];
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic wait_idle();
        int n = 0;
        do begin
            apb(1'b0, TX_PAYLOAD_ACCESS_STATUS, 8'h00);
            n++;
        end while (rd !== 8'h00 && n < 40);
        check("busy cleared", 8'h00, rd);
    endtask

    task automatic ind(input logic [7:0] ac, input logic [7:0] wd);
        if (!ac[7]) begin
            apb(1'b1, TX_PAYLOAD_INDIRECT_DATA, wd);
        end
        apb(1'b1, TX_PAYLOAD_INDIRECT_ADDR_CTRL, ac);
        wait_idle();
    endtask

    task automatic run_frame();
        run <= 1'b1;
        wait (pos == 8'hFF);
        @(posedge clk);
        run <= 1'b0;
        wait (pos == 8'h00);
        repeat (20) @(posedge clk);
    endtask

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        test_done();
    end

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, 7'(TX_PAYLOAD_CONFIG + k), 8'h00);
            check("reset value", REG_RESET, rd);
        end
        apb(1'b0, 7'h64, 8'h00);
        check("unmapped error", 8'h01, {7'h00, err});
        apb(1'b1, TX_PAYLOAD_CONFIG, 8'h01, 1);
        apb(1'b0, TX_PAYLOAD_CONFIG, 8'h00, 1);
        check("channel 1 config", 8'h01, rd);
        apb(1'b0, TX_PAYLOAD_CONFIG, 8'h00);
        check("channel 0 config", 8'h00, rd);
        apb(1'b1, TX_PAYLOAD_INDIRECT_ADDR_CTRL, 8'h05);
        apb(1'b0, TX_PAYLOAD_ACCESS_STATUS, 8'h00);
        check("low index idle", 8'h00, rd);
        apb(1'b1, TX_PAYLOAD_INDIRECT_DATA, 8'h3C);
        apb(1'b1, TX_PAYLOAD_INDIRECT_ADDR_CTRL, 8'h43);
        apb(1'b1, TX_PAYLOAD_INDIRECT_ADDR_CTRL, 8'hC2);
        apb(1'b0, TX_PAYLOAD_ACCESS_STATUS, 8'h00);
        check("busy set", 8'h80, rd);
        wait_idle();
        apb(1'b0, TX_PAYLOAD_INDIRECT_ADDR_CTRL, 8'h00);
        check("addr ctrl kept", 8'h43, rd);
        apb(1'b0, TX_PAYLOAD_INDIRECT_DATA, 8'h00);
        check("buffer kept", 8'h3C, rd);
        ind(8'h20, 8'hFF);
        ind(8'h61, 8'hFF);
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, TX_PAYLOAD_INDIRECT_DATA, 8'h00);
            ind(rb_idx[k] | 8'h80, 8'h00);
            apb(1'b0, TX_PAYLOAD_INDIRECT_DATA, 8'h00);
            check("indirect readback", rb_val[k], rd);
        end
        for (int s = 2; s < 10; s++) begin
            ind(8'(8'h20 + s), ctl[s-2]);
        end
        run_frame();
        for (int s = 2; s < 10; s++) begin
            check("slot disabled", 8'h5A, capt[s]);
        end
        apb(1'b1, TX_PAYLOAD_CONFIG, 8'h01);
        run_frame();
        for (int s = 2; s < 10; s++) begin
            check("slot data", exp[s-2], capt[s]);
        end
        check("pin signaling", 8'h55, capg[1]);
        mode <= 1'b1;
        run_frame();
        check("check stream", 8'h5A, chk_sr);
        check("check count", 8'h10, 8'(n_cv));
        check("slave loopback", 8'hC3, capt[7]);
        check("extract keeps data", 8'h5A, capt[8]);
        check("stored signaling", 8'h5F, capg[1]);
        test_done();
    end
endmodule
